// ===== verilog/csd_consts.vh
// constants for the serial command decoder of the can controller
`ifndef CSD_CONSTS_VH
`define CSD_CONSTS_VH

// ****************************************
// read opcodes
// ****************************************
`define CSD_OP_RD_GPIN      8'hE8
`define CSD_OP_RD_RXERR     8'hEA
`define CSD_OP_RD_TXERR     8'hEC
`define CSD_OP_RD_HIST      8'hEE
`define CSD_OP_RSV_A        8'h4E
`define CSD_OP_RSV_B        8'hF4
`define CSD_OP_RSV_C        8'hF6
`define CSD_OP_RD_BOCNT     8'hF8
`define CSD_OP_RD_TTAG      8'hFA

// ****************************************
// opcodes without data
// ****************************************
`define CSD_OP_ABORT        8'h52
`define CSD_OP_TXQ_CLR      8'h54
`define CSD_OP_DEV_RST      8'h56
`define CSD_OP_TTAG_CLR     8'h58
`define CSD_OP_RXQ_CLR      8'h5A

// ****************************************
// write opcodes
// ****************************************
`define CSD_OP_WR_TXQ       8'h12
`define CSD_OP_WR_FIRST_CONTROL_REG     8'h14
`define CSD_OP_WR_SECOND_CONTROL_REG     8'h16
`define CSD_OP_WR_BT0       8'h18
`define CSD_OP_WR_BT1       8'h1A
`define CSD_OP_WR_IEN       8'h1C
`define CSD_OP_WR_SFEN      8'h1E
`define CSD_OP_WR_GPIN      8'h22
`define CSD_OP_WR_RXERR     8'h24
`define CSD_OP_WR_TXERR     8'h26
`define CSD_OP_FLT_FIRST    8'h62
`define CSD_OP_FLT_LAST     8'h72
`define CSD_OP_MSK_FIRST    8'h74
`define CSD_OP_MSK_LAST     8'h84

// ****************************************
// field positions, counts and reset values
// ****************************************
`define CSD_SECOND_CONTROL_REG_TRANSMIT_ENABLE_BIT_BIT  6
`define CSD_SECOND_CONTROL_REG_SINGLE_MESSAGE_SEND_BIT_BIT  5
`define CSD_IDE_BIT         3
`define CSD_CFG_RST         8'h00
`define CSD_ID_BYTES        3'h6
`define CSD_HIST_BYTES      4'h3
`define CSD_TTAG_BYTES      4'h2
`define CSD_MAX_MSGS        4'h8
`define CSD_STD_HDR         4'h4
`define CSD_EXT_HDR         4'h6
`define CSD_EXT_POS         4'h3
`define CSD_MAX_DLC         4'h8
`define CSD_NO_LEN          4'hF
`define CSD_TXQ_W           9

`endif

// ===== verilog/csd_buf2.v
// two-entry buffer with valid and ready on both sides and registered outputs
module csd_buf2 #(
   parameter W = 9
) (
   input  wire         clk,
   input  wire         rst,
   input  wire         flush,
   input  wire         in_valid,
   input  wire [W-1:0] in_data,
   output wire         in_ready,
   output reg          out_valid,
   output reg  [W-1:0] out_data,
   input  wire         out_ready
);
   reg [W-1:0] spare_q;
   reg         spare_v_q;
   wire        pop;
   wire        push;

   assign in_ready = ~spare_v_q;
   assign pop      = out_valid & out_ready;
   assign push     = in_valid & ~spare_v_q;

   // head entry always drives the outputs so they come straight from flops
   always @(posedge clk) begin
      if (rst | flush) begin
         out_valid <= 1'b0;
         out_data  <= {W{1'b0}};
         spare_q   <= {W{1'b0}};
         spare_v_q <= 1'b0;
      end else if (pop) begin
         if (spare_v_q) begin
            out_data  <= spare_q;
            spare_v_q <= 1'b0;
         end else begin
            out_valid <= push;
            out_data  <= in_data;
         end
      end else if (push) begin
         if (!out_valid) begin
            out_valid <= 1'b1;
            out_data  <= in_data;
         end else begin
            spare_q   <= in_data;
            spare_v_q <= 1'b1;
         end
      end
   end
endmodule // csd_buf2

// ===== verilog/csd_decoder.v
// serial host command decoder of a standalone can controller
// What this block does
// - each chip-select frame starts with one 8-bit opcode, its data follows in-frame
// - 0xE8 returns one byte: the general pin enable register
// - 0xEA returns receive error counter, 0xEC transmit error counter, one byte each
// - 0xEE returns three bytes from the oldest transmit history entry
// - 0xF8 returns one byte: bus-off recessive sequence count
// - 0xFA returns time tag counter, upper byte then lower byte
// - 0x52 aborts current transmission now and clears send enable bits
// - 0x54 empties transmit queue, clears send enable bits, current frame finishes
// - 0x58 resets the free-running time tag counter
// - 0x12 loads 1 to 8 messages: standard 4-12 bytes, extended 6-14 bytes
// - 0x14 and 0x16 write one byte to first and second control registers
// - 0x18 and 0x1A write one byte to first and second bit timing registers
// - 0x1C writes one byte to the interrupt enable register
// - 0x1E writes one byte to the status flag enable register
// - 0x22 writes one byte to the general pin enable register
// - 0x24 and 0x26 write receive and transmit error counters, test only
// - 0x62 to 0x72 take six bytes for filter identifiers 0 to 7
// - 0x74 to 0x84 take six bytes for mask identifiers 0 to 7
`include "csd_consts.vh"

module csd_decoder (
   input  wire        CORE_CLK,
   input  wire        SYS_RST,
   input  wire        SPI_CS_N,
   input  wire        SPI_SCK,
   input  wire        SPI_MOSI,
   output reg         SPI_MISO,
   output reg         SPI_MISO_OE,
   output reg  [7:0]  FIRST_CONTROL_REG,
   output reg  [7:0]  SECOND_CONTROL_REG,
   output reg  [7:0]  FIRST_BIT_TIMING_REG,
   output reg  [7:0]  SECOND_BIT_TIMING_REG,
   output reg  [7:0]  INTERRUPT_ENABLE_REG,
   output reg  [7:0]  STATUS_FLAG_ENABLE_REG,
   output reg  [7:0]  GENERAL_PIN_ENABLE_REG,
   input  wire [7:0]  RECEIVE_ERROR_COUNTER,
   input  wire [7:0]  TRANSMIT_ERROR_COUNTER,
   output reg         REC_WE,
   output reg         TEC_WE,
   output reg  [7:0]  ERR_CNT_WDATA,
   input  wire [23:0] HIST_DATA,
   output reg         HIST_POP,
   input  wire [7:0]  BUSOFF_RCNT,
   input  wire [15:0] TIME_TAG,
   output reg         TIME_TAG_CLR,
   output reg         ABORT_TX,
   output reg         TXQ_CLR,
   output reg         DEV_RESET,
   output reg         RXQ_CLR,
   output reg         FLT_WE,
   output reg         FLT_MASK,
   output reg  [2:0]  FLT_IDX,
   output reg  [2:0]  FLT_BYTE,
   output reg  [7:0]  FLT_DATA,
   output wire        TXQ_VALID,
   output wire [7:0]  TXQ_DATA,
   output wire        TXQ_LAST,
   input  wire        TXQ_READY,
   output reg         TXQ_OVF
);

   // ****************************************
   // helper functions
   // ****************************************
   // {valid, mask, index}; 0x70 and 0x80 are gaps in the opcode ladder
   function [4:0] id_slot;
      input [7:0] op;
      begin
         id_slot = 5'h00;
         if (op >= `CSD_OP_FLT_FIRST && op <= 8'h6E && !op[0])
            id_slot = {2'b10, op[3:1] - 3'h1};
         else if (op == `CSD_OP_FLT_LAST)
            id_slot = 5'h17;
         else if (op >= `CSD_OP_MSK_FIRST && op <= 8'h7E && !op[0])
            id_slot = {2'b11, op[3:1] - 3'h2};
         else if (op == 8'h82 || op == `CSD_OP_MSK_LAST)
            id_slot = {2'b11, 3'h6 | {2'b00, op[2]}};
      end
   endfunction

   // a length code above eight counts as eight
   function [3:0] dlc_len;
      input [3:0] hdr;
      input [3:0] dlc;
      begin
         dlc_len = hdr + ((dlc > `CSD_MAX_DLC) ? `CSD_MAX_DLC : dlc);
      end
   endfunction

   // ****************************************
   // pin synchronisers and edge detection
   // ****************************************
   // bit 0 is the metastable stage, read only by bit 1; sck bit 2 is the edge history
   reg [1:0] cs_q;
   reg [2:0] sck_q;
   reg [1:0] mosi_q;

   always @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         cs_q   <= 2'h3;
         sck_q  <= 3'h0;
         mosi_q <= 2'h0;
      end else begin
         cs_q   <= {cs_q[0], SPI_CS_N};
         sck_q  <= {sck_q[1:0], SPI_SCK};
         mosi_q <= {mosi_q[0], SPI_MOSI};
      end
   end

   wire sck_rise = sck_q[1] & ~sck_q[2];
   wire sck_fall = ~sck_q[1] & sck_q[2];
   wire active   = ~cs_q[1];

   // ****************************************
   // byte framing
   // ****************************************
   reg  [6:0] rx_q;
   reg  [2:0] bit_q;
   reg  [3:0] byte_q;
   reg  [7:0] op_q;
   wire [7:0] rx_byte = {rx_q, mosi_q[1]};
   wire       done    = active & sck_rise & (bit_q == 3'h7);
   wire       is_op   = (byte_q == 4'h0);
   wire [7:0] op_now  = is_op ? rx_byte : op_q;
   wire [4:0] slot    = id_slot(op_q);

   always @(posedge CORE_CLK) begin
      if (SYS_RST || !active) begin
         rx_q   <= 7'h00;
         bit_q  <= 3'h0;
         byte_q <= 4'h0;
      end else if (sck_rise) begin
         rx_q  <= rx_byte[6:0];
         bit_q <= bit_q + 3'h1;
         if (done && byte_q != 4'hF)
            byte_q <= byte_q + 4'h1;
      end
   end

   // ****************************************
   // read data selection and shift-out
   // ****************************************
   reg  [23:0] hist_q;
   reg  [15:0] ttag_q;
   reg  [7:0]  tx_sr_q;
   reg  [7:0]  rd_byte;
   wire [23:0] hist_w = is_op ? HIST_DATA : hist_q;
   wire [15:0] ttag_w = is_op ? TIME_TAG : ttag_q;

   // reserved test opcodes and unlisted ones fall to the zero default
   always @* begin
      rd_byte = 8'h00;
      case (op_now)
         `CSD_OP_RD_GPIN:
            if (byte_q == 4'h0) rd_byte = GENERAL_PIN_ENABLE_REG;
         `CSD_OP_RD_RXERR:
            if (byte_q == 4'h0) rd_byte = RECEIVE_ERROR_COUNTER;
         `CSD_OP_RD_TXERR:
            if (byte_q == 4'h0) rd_byte = TRANSMIT_ERROR_COUNTER;
         `CSD_OP_RD_HIST: begin
            if (byte_q == 4'h0) rd_byte = hist_w[23:16];
            if (byte_q == 4'h1) rd_byte = hist_w[15:8];
            if (byte_q == 4'h2) rd_byte = hist_w[7:0];
         end
         `CSD_OP_RD_BOCNT:
            if (byte_q == 4'h0) rd_byte = BUSOFF_RCNT;
         `CSD_OP_RD_TTAG: begin
            if (byte_q == 4'h0) rd_byte = ttag_w[15:8];
            if (byte_q == 4'h1) rd_byte = ttag_w[7:0];
         end
         default: rd_byte = 8'h00;
      endcase
   end

   // mode 0: the next byte is staged at byte end and put out on the following falling edge
   always @(posedge CORE_CLK) begin
      if (SYS_RST || !active) begin
         tx_sr_q     <= 8'h00;
         SPI_MISO    <= 1'b0;
         SPI_MISO_OE <= 1'b0;
      end else begin
         SPI_MISO_OE <= 1'b1;
         if (done) begin
            tx_sr_q <= rd_byte;
         end else if (sck_fall) begin
            SPI_MISO <= tx_sr_q[7];
            tx_sr_q  <= {tx_sr_q[6:0], 1'b0};
         end
      end
   end

   // ****************************************
   // opcode capture and command execution
   // ****************************************
   // snapshots keep multi-byte answers coherent while the source moves on
   always @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         op_q   <= 8'h00;
         hist_q <= 24'h000000;
         ttag_q <= 16'h0000;
      end else if (done && is_op) begin
         op_q   <= rx_byte;
         hist_q <= HIST_DATA;
         ttag_q <= TIME_TAG;
      end
   end

   always @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         HIST_POP     <= 1'b0;
         TIME_TAG_CLR <= 1'b0;
         ABORT_TX     <= 1'b0;
         TXQ_CLR      <= 1'b0;
         DEV_RESET    <= 1'b0;
         RXQ_CLR      <= 1'b0;
      end else begin
         HIST_POP     <= done & is_op & (rx_byte == `CSD_OP_RD_HIST);
         TIME_TAG_CLR <= done & is_op & (rx_byte == `CSD_OP_TTAG_CLR);
         ABORT_TX     <= done & is_op & (rx_byte == `CSD_OP_ABORT);
         TXQ_CLR      <= done & is_op & (rx_byte == `CSD_OP_TXQ_CLR);
         DEV_RESET    <= done & is_op & (rx_byte == `CSD_OP_DEV_RST);
         RXQ_CLR      <= done & is_op & (rx_byte == `CSD_OP_RXQ_CLR);
      end
   end

   // ****************************************
   // configuration registers
   // ****************************************
   wire wr1 = done & (byte_q == 4'h1);    // only the first data byte counts
   wire rst_cmd = done & is_op & (rx_byte == `CSD_OP_DEV_RST);
   wire stop_tx = done & is_op &
                  (rx_byte == `CSD_OP_ABORT || rx_byte == `CSD_OP_TXQ_CLR);

   always @(posedge CORE_CLK) begin
      if (SYS_RST || rst_cmd) begin
         FIRST_CONTROL_REG      <= `CSD_CFG_RST;
         SECOND_CONTROL_REG     <= `CSD_CFG_RST;
         FIRST_BIT_TIMING_REG   <= `CSD_CFG_RST;
         SECOND_BIT_TIMING_REG  <= `CSD_CFG_RST;
         INTERRUPT_ENABLE_REG   <= `CSD_CFG_RST;
         STATUS_FLAG_ENABLE_REG <= `CSD_CFG_RST;
         GENERAL_PIN_ENABLE_REG <= `CSD_CFG_RST;
      end else if (stop_tx) begin
         SECOND_CONTROL_REG[`CSD_SECOND_CONTROL_REG_TRANSMIT_ENABLE_BIT_BIT] <= 1'b0;
         SECOND_CONTROL_REG[`CSD_SECOND_CONTROL_REG_SINGLE_MESSAGE_SEND_BIT_BIT] <= 1'b0;
      end else if (wr1) begin
         case (op_q)
            `CSD_OP_WR_FIRST_CONTROL_REG: FIRST_CONTROL_REG      <= rx_byte;
            `CSD_OP_WR_SECOND_CONTROL_REG: SECOND_CONTROL_REG     <= rx_byte;
            `CSD_OP_WR_BT0:   FIRST_BIT_TIMING_REG   <= rx_byte;
            `CSD_OP_WR_BT1:   SECOND_BIT_TIMING_REG  <= rx_byte;
            `CSD_OP_WR_IEN:   INTERRUPT_ENABLE_REG   <= rx_byte;
            `CSD_OP_WR_SFEN:  STATUS_FLAG_ENABLE_REG <= rx_byte;
            `CSD_OP_WR_GPIN:  GENERAL_PIN_ENABLE_REG <= rx_byte;
            default: ;
         endcase
      end
   end

   // error counters live in the protocol engine; this block only hands over the write
   always @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         REC_WE        <= 1'b0;
         TEC_WE        <= 1'b0;
         ERR_CNT_WDATA <= 8'h00;
      end else begin
         REC_WE <= wr1 & (op_q == `CSD_OP_WR_RXERR);
         TEC_WE <= wr1 & (op_q == `CSD_OP_WR_TXERR);
         if (wr1)
            ERR_CNT_WDATA <= rx_byte;
      end
   end

   // ****************************************
   // filter and mask identifier writes
   // ****************************************
   always @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         FLT_WE   <= 1'b0;
         FLT_MASK <= 1'b0;
         FLT_IDX  <= 3'h0;
         FLT_BYTE <= 3'h0;
         FLT_DATA <= 8'h00;
      end else begin
         FLT_WE <= 1'b0;
         // bytes past the sixth are ignored
         if (done && !is_op && slot[4] && byte_q <= {1'b0, `CSD_ID_BYTES}) begin
            FLT_WE   <= 1'b1;
            FLT_MASK <= slot[3];
            FLT_IDX  <= slot[2:0];
            FLT_BYTE <= byte_q[2:0] - 3'h1;
            FLT_DATA <= rx_byte;
         end
      end
   end

   // ****************************************
   // transmit queue loading
   // ****************************************
   reg  [3:0] pos_q;
   reg  [3:0] len_q;
   reg        ext_q;
   reg  [3:0] msgs_q;
   wire [3:0] pos     = pos_q + 4'h1;
   wire       ext_now = (pos == `CSD_EXT_POS) ? rx_byte[`CSD_IDE_BIT] : ext_q;
   reg  [3:0] len_now;
   wire       q_byte  = done & !is_op & (op_q == `CSD_OP_WR_TXQ) &
                        (msgs_q < `CSD_MAX_MSGS);
   wire       q_last  = (pos == len_now);
   wire       q_ready;

   // message length becomes known at the length-code byte of each frame format
   always @* begin
      len_now = len_q;
      if (!ext_now && pos == `CSD_STD_HDR)
         len_now = dlc_len(`CSD_STD_HDR, rx_byte[3:0]);
      else if (ext_now && pos == `CSD_EXT_HDR)
         len_now = dlc_len(`CSD_EXT_HDR, rx_byte[3:0]);
   end

   always @(posedge CORE_CLK) begin
      if (SYS_RST || !active) begin
         pos_q  <= 4'h0;
         len_q  <= `CSD_NO_LEN;
         ext_q  <= 1'b0;
         msgs_q <= 4'h0;
      end else if (q_byte) begin
         ext_q <= ext_now;
         if (q_last) begin
            pos_q  <= 4'h0;
            len_q  <= `CSD_NO_LEN;
            msgs_q <= msgs_q + 4'h1;
         end else begin
            pos_q <= pos;
            len_q <= len_now;
         end
      end
   end

   // the host cannot be stalled, so a byte refused by a full buffer is lost and flagged
   always @(posedge CORE_CLK) begin
      if (SYS_RST)
         TXQ_OVF <= 1'b0;
      else if (q_byte && !q_ready)
         TXQ_OVF <= 1'b1;
      else if (done && is_op && rx_byte == `CSD_OP_WR_TXQ)
         TXQ_OVF <= 1'b0;
   end

   csd_buf2 #(
      .W         (`CSD_TXQ_W)
   ) u_txq_buf (
      .clk       (CORE_CLK),
      .rst       (SYS_RST),
      .flush     (ABORT_TX | TXQ_CLR), // empties together with the visible strobe
      .in_valid  (q_byte),
      .in_data   ({q_last, rx_byte}),
      .in_ready  (q_ready),
      .out_valid (TXQ_VALID),
      .out_data  ({TXQ_LAST, TXQ_DATA}),
      .out_ready (TXQ_READY)
   );

endmodule // csd_decoder

// ===== bench/csd_decoder_sva.sv
// concurrent checks on the ports of the serial command decoder
module csd_decoder_sva (
   input wire logic       CORE_CLK,
   input wire logic       SYS_RST,
   input wire logic       SPI_CS_N,
   input wire logic       SPI_SCK,
   input wire logic       SPI_MISO,
   input wire logic       SPI_MISO_OE,
   input wire logic [7:0] FIRST_CONTROL_REG,
   input wire logic [7:0] SECOND_CONTROL_REG,
   input wire logic       REC_WE,
   input wire logic       TEC_WE,
   input wire logic       ABORT_TX,
   input wire logic       TXQ_CLR,
   input wire logic       DEV_RESET,
   input wire logic       FLT_WE,
   input wire logic       FLT_MASK,
   input wire logic [2:0] FLT_IDX,
   input wire logic [2:0] FLT_BYTE,
   input wire logic       TXQ_VALID,
   input wire logic [7:0] TXQ_DATA,
   input wire logic       TXQ_READY,
   input wire logic       TXQ_OVF
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);
   // the pin is only driven inside a frame; allow the sync delay of the select
   a_oe_idle: assert property (SPI_CS_N [*6] |-> !SPI_MISO_OE)
      else $error("miso enable high with chip select idle");
   a_oe_frame: assert property (!SPI_CS_N [*6] |-> SPI_MISO_OE)
      else $error("miso enable low inside a frame");
   a_miso_fall: assert property (SPI_MISO_OE && $changed(SPI_MISO) |-> !SPI_SCK)
      else $error("miso changed while serial clock high");
   a_abort_bits: assert property (ABORT_TX |-> ##[0:2] SECOND_CONTROL_REG[6:5] == 2'h0)
      else $error("send enable bits survive abort");
   a_abort_once: assert property (ABORT_TX |=> !ABORT_TX)
      else $error("abort pulse longer than one cycle");
   a_flush_bits: assert property (TXQ_CLR |-> ##[0:2] SECOND_CONTROL_REG[6:5] == 2'h0)
      else $error("send enable bits survive queue clear");
   a_devrst_cfg: assert property (DEV_RESET |-> ##[0:2]
      (FIRST_CONTROL_REG == 8'h00 && SECOND_CONTROL_REG == 8'h00))
      else $error("config not cleared by device reset");
   a_txq_hold: assert property (TXQ_VALID && !TXQ_READY && !ABORT_TX && !TXQ_CLR
      |=> TXQ_VALID && $stable(TXQ_DATA))
      else $error("queue word changed while stalled");
   a_ovf_cause: assert property ($rose(TXQ_OVF) |-> $past(TXQ_VALID))
      else $error("overflow flagged with empty buffer head");
   a_err_we: assert property (REC_WE |-> !TEC_WE ##1 !REC_WE)
      else $error("error counter write strobes overlap");
   a_flt_byte: assert property (FLT_WE |-> FLT_BYTE <= 3'h5)
      else $error("filter byte index beyond six bytes");
   c_overflow: cover property ($rose(TXQ_OVF));
   c_mask_last: cover property (FLT_WE && FLT_MASK && FLT_IDX == 3'h7);
   c_devrst: cover property (DEV_RESET);
endmodule // csd_decoder_sva

// ===== bench/csd_host.sv
// host-side serial master model: chip select, serial clock and data out
module csd_host (
   input  wire logic clk,
   output logic      cs_n,
   output logic      sck,
   output logic      mosi,
   input  wire logic miso
);
   timeunit 1ns;
   timeprecision 1ps;
   // half period in core cycles; raise it to act as a slow host
   int half = 8;
   initial begin
      cs_n = 1'h1;
      sck  = 1'h0;
      mosi = 1'h0;
   end
   // select, then opcode first and data directly after in the same frame
   task automatic start;
      cs_n <= 1'h0;
      repeat (4) @(posedge clk);
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         mosi <= tx[i];
         repeat (half) @(posedge clk);
         sck <= 1'h1;
         rx[i] = miso;
         repeat (half) @(posedge clk);
         sck <= 1'h0;
      end
   endtask
   // select released after each instruction, never chained
   task automatic stop;
      repeat (half) @(posedge clk);
      cs_n <= 1'h1;
      mosi <= ~mosi;
      repeat (2 * half) @(posedge clk);
   endtask
endmodule // csd_host

// ===== bench/csd_decoder_test.sv
// self-checking bench for the serial command decoder
module csd_decoder_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        CORE_CLK, SYS_RST, SPI_CS_N, SPI_SCK, SPI_MOSI, TXQ_READY;
   logic [7:0]  RECEIVE_ERROR_COUNTER, TRANSMIT_ERROR_COUNTER, BUSOFF_RCNT;
   logic [23:0] HIST_DATA;
   logic [15:0] TIME_TAG;
   wire         SPI_MISO, SPI_MISO_OE, REC_WE, TEC_WE, HIST_POP, TIME_TAG_CLR, ABORT_TX;
   wire         TXQ_CLR, DEV_RESET, RXQ_CLR, FLT_WE, FLT_MASK, TXQ_VALID, TXQ_LAST, TXQ_OVF;
   wire [7:0]   FIRST_CONTROL_REG, SECOND_CONTROL_REG, FIRST_BIT_TIMING_REG;
   wire [7:0]   SECOND_BIT_TIMING_REG, INTERRUPT_ENABLE_REG, STATUS_FLAG_ENABLE_REG;
   wire [7:0]   GENERAL_PIN_ENABLE_REG, ERR_CNT_WDATA, FLT_DATA, TXQ_DATA;
   wire [2:0]   FLT_IDX, FLT_BYTE;
   wire [55:0]  cfgv = {GENERAL_PIN_ENABLE_REG, STATUS_FLAG_ENABLE_REG, INTERRUPT_ENABLE_REG,
                        SECOND_BIT_TIMING_REG, FIRST_BIT_TIMING_REG, SECOND_CONTROL_REG,
                        FIRST_CONTROL_REG};
   wire [5:0]   pv = {HIST_POP, RXQ_CLR, TIME_TAG_CLR, DEV_RESET, TXQ_CLR, ABORT_TX};
   logic [7:0]  tx [0:31], rx [0:31], flt [0:127], rec_w, tec_w;
   // filter then mask opcodes; the ladder skips 0x70 and 0x80
   logic [7:0]  fop [0:15] = '{8'h62, 8'h64, 8'h66, 8'h68, 8'h6A, 8'h6C, 8'h6E, 8'h72,
                               8'h74, 8'h76, 8'h78, 8'h7A, 8'h7C, 8'h7E, 8'h82, 8'h84};
   logic [7:0]  wop [0:6] = '{8'h14, 8'h16, 8'h18, 8'h1A, 8'h1C, 8'h1E, 8'h22};
   // one standard message of two data bytes, one extended with length code above 8
   logic [7:0]  msg [0:19] = '{8'hA1, 8'h11, 8'h00, 8'h02, 8'hD0, 8'hD1, 8'hB2, 8'h22,
                               8'h08, 8'h33, 8'h44, 8'h09, 8'hE0, 8'hE1, 8'hE2, 8'hE3,
                               8'hE4, 8'hE5, 8'hE6, 8'hE7};
   logic [7:0]  qd [$];
   int          lp [$];
   int          cnt [0:5];
   int          qn, cyc, mismatches, compares;
   logic        stall;

   csd_decoder csd_decoder_inst (.*);
   csd_host csd_host_inst (.clk(CORE_CLK), .cs_n(SPI_CS_N), .sck(SPI_SCK), .mosi(SPI_MOSI),
                           .miso(SPI_MISO));

   initial begin
      CORE_CLK = 1'h0;
      forever #5 CORE_CLK = ~CORE_CLK;
   end

   // ****************************************
   // monitors and timeout
   // ****************************************
   always @(posedge CORE_CLK) begin
      cyc <= cyc + 1;
      TXQ_READY <= !stall && cyc[3];
      if (REC_WE) rec_w <= ERR_CNT_WDATA;
      if (TEC_WE) tec_w <= ERR_CNT_WDATA;
      if (FLT_WE) flt[{FLT_MASK, FLT_IDX, FLT_BYTE}] <= FLT_DATA;
      for (int k = 0; k < 6; k++) cnt[k] <= cnt[k] + int'(pv[k]);
      if (TXQ_VALID && TXQ_READY) begin
         qn <= qn + 1;
         qd.push_back(TXQ_DATA);
         if (TXQ_LAST) lp.push_back(qn);
      end
      // long enough for every frame below with a wide margin
      if (cyc == 60000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   task automatic check(input logic [55:0] seen, input logic [55:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cmd(input logic [7:0] op, input int n);
      logic [7:0] d;
      csd_host_inst.start();
      csd_host_inst.xfer(op, d);
      for (int i = 0; i < n; i++) csd_host_inst.xfer(tx[i], rx[i]);
      csd_host_inst.stop();
   endtask

   task automatic rd(input logic [7:0] op, input int n, input logic [31:0] exp);
      cmd(op, n);
      for (int i = 0; i < n; i++) check(rx[i], exp[8 * (n - 1 - i) +: 8]);
   endtask

   task automatic tally_and_finish;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      SYS_RST = 1'h1;
      stall = 1'h1;
      RECEIVE_ERROR_COUNTER = 8'h3C;
      TRANSMIT_ERROR_COUNTER = 8'hC3;
      BUSOFF_RCNT = 8'h5A;
      TIME_TAG = 16'hBEEF;
      HIST_DATA = 24'h123456;
      for (int i = 0; i < 32; i++) tx[i] = 8'h00;
      repeat (5) @(posedge CORE_CLK);
      SYS_RST <= 1'h0;
      repeat (4) @(posedge CORE_CLK);
      check(cfgv, 24'h0);
      for (int i = 0; i < 7; i++) begin
         tx[0] = (i == 1) ? 8'hFF : 8'(8'h11 * (i + 1));
         cmd(wop[i], 1);
         check(cfgv[8 * i +: 8], tx[0]);
      end
      tx[0] = 8'h00;
      rd(8'hE8, 1, 32'h77);
      csd_host_inst.half = 12;
      rd(8'hEA, 1, 32'h3C);
      csd_host_inst.half = 8;
      rd(8'hEC, 1, 32'hC3);
      rd(8'hF8, 1, 32'h5A);
      rd(8'hFA, 2, 32'hBEEF);
      rd(8'hEE, 4, 32'h12345600);
      check(cnt[5], 1);
      rd(8'h4E, 1, 32'h0);
      rd(8'hF4, 1, 32'h0);
      rd(8'hF6, 1, 32'h0);
      tx[0] = 8'h99;
      cmd(8'h24, 1);
      check(rec_w, 8'h99);
      tx[0] = 8'h66;
      cmd(8'h26, 1);
      check(tec_w, 8'h66);
      cmd(8'h52, 0);
      check({cnt[0], SECOND_CONTROL_REG}, {16'h1, 8'h9F});
      tx[0] = 8'hFF;
      cmd(8'h16, 1);
      cmd(8'h54, 0);
      check({cnt[1], SECOND_CONTROL_REG}, {16'h1, 8'h9F});
      cmd(8'h58, 0);
      check(cnt[3], 1);
      cmd(8'h5A, 0);
      cmd(8'h56, 0);
      check({8'(cnt[4]), 8'(cnt[2])}, 16'h0101);
      check(cfgv, 24'h0);
      for (int k = 0; k < 16; k++) begin
         for (int b = 0; b < 6; b++) tx[b] = 8'(k * 16 + b);
         cmd(fop[k], 6);
         for (int b = 0; b < 6; b++) check(flt[k * 8 + b], tx[b]);
      end
      // consumer stalls every other eight cycles while the queue is loaded
      stall = 1'h0;
      for (int i = 0; i < 20; i++) tx[i] = msg[i];
      cmd(8'h12, 20);
      for (int w = 0; w < 400 && qn < 20; w++) @(posedge CORE_CLK);
      for (int i = 0; i < 20; i++) check(qd[i], msg[i]);
      check({8'(lp.size()), 8'(lp[0]), 8'(lp[1])}, {8'h2, 8'h5, 8'h13});
      stall = 1'h1;
      cmd(8'h12, 3);
      check(TXQ_OVF, 1'h1);
      stall = 1'h0;
      for (int w = 0; w < 400 && qn < 22; w++) @(posedge CORE_CLK);
      repeat (40) @(posedge CORE_CLK);
      check({8'(qn), qd[20], qd[21]}, {8'h16, msg[0], msg[1]});
      tally_and_finish();
   end
endmodule // csd_decoder_test

bind csd_decoder csd_decoder_sva csd_decoder_sva_inst (
   .CORE_CLK, .SYS_RST, .SPI_CS_N, .SPI_SCK, .SPI_MISO, .SPI_MISO_OE, .FIRST_CONTROL_REG,
   .SECOND_CONTROL_REG, .REC_WE, .TEC_WE, .ABORT_TX, .TXQ_CLR, .DEV_RESET, .FLT_WE,
   .FLT_MASK, .FLT_IDX, .FLT_BYTE, .TXQ_VALID, .TXQ_DATA, .TXQ_READY, .TXQ_OVF
);
